/* core/pcd_channel_dividers.v */
// Three programmable channel dividers with APB register access.
// Assumes clk_in is the divider input clock and the sync pin is
// asynchronous to it; a bypassed channel's clock is passed by an
// external mux steered by bypass_out.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "pcd_regs.vh"

module pcd_channel_dividers (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // APB slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   // Synchronisation request pin, asynchronous
   input wire sync_in,
   // Divided outputs for the differential output pairs
   output reg [2:0] div_clk_out,
   output reg [2:0] duty_fix_out,
   output reg [2:0] bypass_out
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Total ratio from the low and high counts
   function [5:0] pcd_ratio;
      input [3:0] low_cnt;
      input [3:0] high_cnt;
      begin
         pcd_ratio = {2'b00, low_cnt} + {2'b00, high_cnt} + 6'h02;
      end
   endfunction

   // High phase length in cycles, corrected or as programmed
   function [5:0] pcd_high_len;
      input [3:0] low_cnt;
      input [3:0] high_cnt;
      input corr_on;
      reg [5:0] total;
      begin
         total = pcd_ratio(low_cnt, high_cnt);
         if (corr_on) begin
            pcd_high_len = {1'b0, total[5:1]};
         end else begin
            pcd_high_len = {2'b00, high_cnt} + 6'h01;
         end
      end
   endfunction

   // Load value for the phase counter at the start of a high phase.
   // The counter runs down to zero, so it holds the length less one.
   // The longest high phase is sixteen cycles, so five bits are enough
   // and the top bit of the six-bit length is always zero here.
   function [4:0] pcd_high_cnt;
      input [3:0] low_cnt;
      input [3:0] high_cnt;
      input corr_on;
      reg [5:0] len;
      begin
         len = pcd_high_len(low_cnt, high_cnt, corr_on) - 6'h01;
         pcd_high_cnt = len[4:0];
      end
   endfunction

   // Load value for the phase counter at the start of a low phase.
   // The low phase is whatever the high phase leaves of the period.
   // The longest is sixteen cycles, again within five bits.
   function [4:0] pcd_low_cnt;
      input [3:0] low_cnt;
      input [3:0] high_cnt;
      input corr_on;
      reg [5:0] len;
      begin
         len = pcd_ratio(low_cnt, high_cnt)
            - pcd_high_len(low_cnt, high_cnt, corr_on) - 6'h01;
         pcd_low_cnt = len[4:0];
      end
   endfunction

   // Odd total ratio, which needs the external half-cycle extend
   // when correction is on
   function pcd_is_odd;
      input [3:0] low_cnt;
      input [3:0] high_cnt;
      reg [5:0] total;
      begin
         total = pcd_ratio(low_cnt, high_cnt);
         pcd_is_odd = total[0];
      end
   endfunction

   // Startup delay in input cycles from phase and start-high
   function [5:0] pcd_delay;
      input start_high;
      input [3:0] phase;
      input [3:0] low_cnt;
      reg [5:0] phi;
      begin
         phi = {1'b0, start_high, phase};
         if (phi < `PCD_PHASE_WRAP) begin
            pcd_delay = phi;
         end else begin
            pcd_delay = phi - `PCD_PHASE_WRAP + {2'b00, low_cnt} + 6'h01;
         end
      end
   endfunction

   // Register slot from a word index, 4'hf when unmapped
   function [3:0] pcd_slot;
      input [11:0] idx;
      reg [11:0] rel;
      begin
         rel = idx - `PCD_IDX_DIV0_COUNTS;
         if (idx < `PCD_IDX_DIV0_COUNTS) begin
            pcd_slot = 4'hf;
         end else if (rel < `PCD_NUM_REGS) begin
            pcd_slot = rel[3:0];
         end else begin
            pcd_slot = 4'hf;
         end
      end
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg [7:0] regs_ff [0:8]; // Software view, three bytes per divider
   reg sync_meta_ff; // First synchroniser stage
   reg sync_sync_ff; // Second synchroniser stage
   reg sync_prev_ff; // Edge detector history
   wire sync_evt; // One-cycle sync event
   wire [11:0] word_idx; // APB word index
   wire [3:0] slot; // Decoded register slot
   wire is_status; // Status register selected
   wire acc_done; // Access completes at this edge
   reg [3:0] act_low_ff [0:2]; // Active low count
   reg [3:0] act_high_ff [0:2]; // Active high count
   reg [2:0] act_byp_ff; // Active bypass
   reg [2:0] act_corr_ff; // Active correction enable
   reg [4:0] cnt_ff [0:2]; // Remaining cycles in phase
   reg [5:0] dly_ff [0:2]; // Remaining startup delay
   reg [2:0] dly_busy_ff; // Delay in progress
   reg [2:0] start_hi_ff; // Level taken after delay
   reg [7:0] status_val; // Live status byte
   integer i; // Engine loop index
   integer k; // Register reset loop index

   // ****************************************************************
   // Sync pin synchroniser and edge detect
   // ****************************************************************

   // The sync pin comes from outside this clock domain. Only the
   // second stage is read by logic; the first may go metastable.
   // The history flop idles low like the pin, so no false event
   // follows reset. A rising pin edge acts at the third clock edge.
   // Two flip-flops before any logic, then a rising edge detect
   always @(posedge clk_in) begin
      if (rst_in) begin
         sync_meta_ff <= 1'b0;
         sync_sync_ff <= 1'b0;
         sync_prev_ff <= 1'b0;
      end else begin
         sync_meta_ff <= sync_in;
         sync_sync_ff <= sync_meta_ff;
         sync_prev_ff <= sync_sync_ff;
      end
   end

   assign sync_evt = sync_sync_ff & ~sync_prev_ff;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign word_idx = {2'b00, paddr_in[11:2]};
   assign slot = pcd_slot(word_idx);
   assign is_status = (word_idx == `PCD_IDX_STATUS);
   assign acc_done = psel_in & penable_in & pready_out;

   // Status byte: levels, pending delays, bypass states of channels 0 and 2
   always @* begin
      status_val = 8'h00;
      status_val[`PCD_STAT_LEVEL_LSB +: 3] = div_clk_out;
      status_val[`PCD_STAT_DELAY_LSB +: 3] = dly_busy_ff;
      status_val[`PCD_STAT_BYPASS_LSB +: 2] = act_byp_ff[1:0];
      status_val[7] = act_byp_ff[2];
   end

   // Every access gets exactly one wait state: the first access cycle
   // prepares the answer, the second shows it with ready. Read data
   // is registered, so the output comes straight from a flop. Writes
   // to the status word and unmapped indices are refused with an
   // error; an error never comes without ready.
   // One wait state, registered data and error at completion
   always @(posedge clk_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
         prdata_out <= 32'h00000000;
         pslverr_out <= 1'b0;
      end else if (psel_in & penable_in & ~pready_out) begin
         // First access cycle: prepare the answer
         pready_out <= 1'b1;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
         if (is_status) begin
            pslverr_out <= pwrite_in;
            prdata_out <= {24'h000000, status_val};
         end else if (slot != 4'hf) begin
            prdata_out <= {24'h000000, regs_ff[slot]};
         end else begin
            pslverr_out <= 1'b1;
         end
      end else begin
         // Completion edge or idle: drop the answer
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   // Register writes take effect at the completion edge
   always @(posedge clk_in) begin
      if (rst_in) begin
         for (k = 0; k < `PCD_NUM_DIV; k = k + 1) begin
            regs_ff[3 * k] <= `PCD_RST_COUNTS;
            regs_ff[3 * k + 1] <= `PCD_RST_BYPASS;
            regs_ff[3 * k + 2] <= `PCD_RST_CORR;
         end
      end else if (acc_done & pwrite_in & (slot != 4'hf)) begin
         regs_ff[slot] <= pwdata_in[7:0];
      end
   end

   // ****************************************************************
   // Divider engines
   // ****************************************************************

   // Branch priority per channel, highest first:
   //   sync      - reload all settings and start the phase delay
   //   bypass    - counter parked, output low, settings tracked
   //   delay     - hold low until the delay runs out, then start
   //   counting  - run down the current phase
   //   high end  - drop low and load the low phase length
   //   boundary  - take new settings and start a high phase
   // Settings only move at a boundary, a sync or while bypassed, so a
   // software write in mid-period never cuts a pulse short.
   // One engine per channel, all counting input clock cycles
   always @(posedge clk_in) begin
      if (rst_in) begin
         for (i = 0; i < `PCD_NUM_DIV; i = i + 1) begin
            act_low_ff[i] <= 4'h0;
            act_high_ff[i] <= 4'h0;
            cnt_ff[i] <= 5'h00;
            dly_ff[i] <= 6'h00;
         end
         act_byp_ff <= 3'b000;
         act_corr_ff <= 3'b111;
         dly_busy_ff <= 3'b000;
         start_hi_ff <= 3'b000;
         div_clk_out <= 3'b000;
         duty_fix_out <= 3'b000;
         bypass_out <= 3'b000;
      end else begin
         for (i = 0; i < `PCD_NUM_DIV; i = i + 1) begin
            if (sync_evt) begin
               // Sync: load everything, including phase settings
               act_low_ff[i] <= regs_ff[3 * i][`PCD_LOW_MSB:`PCD_LOW_LSB];
               act_high_ff[i] <= regs_ff[3 * i][`PCD_HIGH_MSB:`PCD_HIGH_LSB];
               act_byp_ff[i] <= regs_ff[3 * i + 1][`PCD_BYPASS_BIT];
               act_corr_ff[i] <= ~regs_ff[3 * i + 2][`PCD_CORR_OFF_BIT];
               start_hi_ff[i] <= regs_ff[3 * i + 1][`PCD_START_HIGH_BIT];
               dly_ff[i] <= pcd_delay(regs_ff[3 * i + 1][`PCD_START_HIGH_BIT],
                  regs_ff[3 * i + 1][`PCD_PHASE_MSB:`PCD_PHASE_LSB],
                  regs_ff[3 * i][`PCD_LOW_MSB:`PCD_LOW_LSB]);
               dly_busy_ff[i] <= 1'b1;
               div_clk_out[i] <= 1'b0;
               cnt_ff[i] <= 5'h00;
            end else if (act_byp_ff[i]) begin
               // Bypass: counter idle, settings follow software freely
               act_low_ff[i] <= regs_ff[3 * i][`PCD_LOW_MSB:`PCD_LOW_LSB];
               act_high_ff[i] <= regs_ff[3 * i][`PCD_HIGH_MSB:`PCD_HIGH_LSB];
               act_byp_ff[i] <= regs_ff[3 * i + 1][`PCD_BYPASS_BIT];
               // A delay left pending by a sync while bypassed is dropped,
               // so leaving bypass restarts cleanly at a period boundary
               dly_busy_ff[i] <= 1'b0;
               act_corr_ff[i] <= ~regs_ff[3 * i + 2][`PCD_CORR_OFF_BIT];
               div_clk_out[i] <= 1'b0;
               cnt_ff[i] <= 5'h00;
            end else if (dly_busy_ff[i]) begin
               // Startup delay: hold low, then start at chosen level
               if (dly_ff[i] == 6'h00) begin
                  dly_busy_ff[i] <= 1'b0;
                  div_clk_out[i] <= start_hi_ff[i];
                  if (start_hi_ff[i]) begin
                     // Start high: run the high phase first
                     cnt_ff[i] <= pcd_high_cnt(act_low_ff[i], act_high_ff[i],
                        act_corr_ff[i]);
                  end else begin
                     // Start low: a full low phase before the first rise
                     cnt_ff[i] <= pcd_low_cnt(act_low_ff[i], act_high_ff[i],
                        act_corr_ff[i]);
                  end
               end else begin
                  dly_ff[i] <= dly_ff[i] - 6'h01;
               end
            end else if (cnt_ff[i] != 5'h00) begin
               cnt_ff[i] <= cnt_ff[i] - 5'h01;
            end else if (div_clk_out[i]) begin
               // End of high phase: go low
               div_clk_out[i] <= 1'b0;
               cnt_ff[i] <= pcd_low_cnt(act_low_ff[i], act_high_ff[i],
                  act_corr_ff[i]);
            end else begin
               // Period boundary: take new settings, start high
               act_low_ff[i] <= regs_ff[3 * i][`PCD_LOW_MSB:`PCD_LOW_LSB];
               act_high_ff[i] <= regs_ff[3 * i][`PCD_HIGH_MSB:`PCD_HIGH_LSB];
               act_byp_ff[i] <= regs_ff[3 * i + 1][`PCD_BYPASS_BIT];
               act_corr_ff[i] <= ~regs_ff[3 * i + 2][`PCD_CORR_OFF_BIT];
               div_clk_out[i] <= ~regs_ff[3 * i + 1][`PCD_BYPASS_BIT];
               cnt_ff[i] <= pcd_high_cnt(regs_ff[3 * i][`PCD_LOW_MSB:`PCD_LOW_LSB],
                  regs_ff[3 * i][`PCD_HIGH_MSB:`PCD_HIGH_LSB],
                  ~regs_ff[3 * i + 2][`PCD_CORR_OFF_BIT]);
            end
            // Half-cycle extend request for odd corrected ratios
            // Even ratios are already balanced; odd ones lean low by half
            // a cycle, which the external cell makes up
            duty_fix_out[i] <= act_corr_ff[i] & ~act_byp_ff[i]
               & pcd_is_odd(act_low_ff[i], act_high_ff[i]);
            bypass_out[i] <= act_byp_ff[i];
         end
      end
   end

endmodule // pcd_channel_dividers

/* core/pcd_regs.vh */
// Register indices, field positions, reset values and bus constants
// for the three output channel dividers.
// Assumes the includer uses a 12-bit APB byte address (index times 4).
`ifndef PCD_REGS_VH
`define PCD_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PCD_IDX_DIV0_COUNTS 12'h190
`define PCD_IDX_DIV0_BYPASS 12'h191
`define PCD_IDX_DIV0_CORR 12'h192
`define PCD_IDX_DIV1_COUNTS 12'h193
`define PCD_IDX_DIV1_BYPASS 12'h194
`define PCD_IDX_DIV1_CORR 12'h195
`define PCD_IDX_DIV2_COUNTS 12'h196
`define PCD_IDX_DIV2_BYPASS 12'h197
`define PCD_IDX_DIV2_CORR 12'h198
`define PCD_IDX_STATUS 12'h18f
`define PCD_IDX_STRIDE 12'h003

// ****************************************************************
// Field positions
// ****************************************************************
`define PCD_LOW_MSB 7
`define PCD_LOW_LSB 4
`define PCD_HIGH_MSB 3
`define PCD_HIGH_LSB 0
`define PCD_BYPASS_BIT 7
`define PCD_START_HIGH_BIT 4
`define PCD_PHASE_MSB 3
`define PCD_PHASE_LSB 0
`define PCD_CORR_OFF_BIT 0
`define PCD_STAT_LEVEL_LSB 0
`define PCD_STAT_DELAY_LSB 3
`define PCD_STAT_BYPASS_LSB 6

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define PCD_RST_COUNTS 8'h00
`define PCD_RST_BYPASS 8'h00
`define PCD_RST_CORR 8'h00
`define PCD_NUM_DIV 3
`define PCD_NUM_REGS 9
`define PCD_PHASE_WRAP 6'h10

`endif

/* testbench/pcd_asserts.sv */
// Port checks for the three channel dividers.
// Assumes one clock domain, bound onto pcd_channel_dividers.
`timescale 1ns/10ps
// ****************************************************************
// Checker
// ****************************************************************
module pcd_asserts (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // APB
   input wire psel_in,
   input wire penable_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   // Divider outputs
   input wire [2:0] div_clk_out,
   input wire [2:0] duty_fix_out,
   input wire [2:0] bypass_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   chk_one_wait_state: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
      else $error("access not answered after one wait");
   chk_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   chk_upper_data_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
      else $error("upper read data not zero");
   chk_bypass_holds_low: assert property ((bypass_out & div_clk_out) == 3'h0)
      else $error("bypassed channel toggles");
   chk_fix_not_bypassed: assert property ((bypass_out & duty_fix_out) == 3'h0)
      else $error("correction flag on bypassed channel");
   chk_high_bounded: assert property ($rose(div_clk_out[0]) |-> ##[1:16] !div_clk_out[0])
      else $error("high phase too long");
   chk_low_bounded: assert property ($fell(div_clk_out[0]) && !bypass_out[0]
      |-> ##[1:64] (div_clk_out[0] || bypass_out[0]))
      else $error("low phase too long");
   // Main scenarios
   cov_error: cover property (pready_out && pslverr_out);
   cov_bypass: cover property (bypass_out[1]);
   cov_fix: cover property (duty_fix_out[2]);
endmodule // pcd_asserts

bind pcd_channel_dividers pcd_asserts i_chk (.clk_in(clk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .div_clk_out(div_clk_out),
   .duty_fix_out(duty_fix_out), .bypass_out(bypass_out));

/* testbench/tb_pcd_channel_dividers.sv */
// Self-checking bench for the three channel dividers.
// Assumes the bench drives APB and the sync pin directly.
`timescale 1ns/10ps
`include "pcd_regs.vh"
module tb_pcd_channel_dividers;
   // Stimulus, responses and counters
   logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, sync_in = 0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, rd;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out;
   wire [2:0] div_clk_out, duty_fix_out, bypass_out;
   logic err;
   int fail_count = 0, cmp_count = 0, hi, lo, t0, t1, t2;
   always #4 clk_in = ~clk_in;
   pcd_channel_dividers i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .sync_in(sync_in), .div_clk_out(div_clk_out),
      .duty_fix_out(duty_fix_out), .bypass_out(bypass_out));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One APB transfer; answer taken at the edge where ready is high
   task apb(input logic wr, input logic [11:0] idx, input logic [7:0] data);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1; pwrite_in <= wr; paddr_in <= {idx[9:0], 2'b00}; pwdata_in <= {24'h0, data};
      @(posedge clk_in);
      penable_in <= 1;
      // Ready, data and error are taken at the rising edge that samples ready high
      do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 20);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 0; penable_in <= 0;
      if (n >= 20) begin fail_count++; results(); end
   endtask
   // Length of one whole high and low phase of a channel
   task measure(input int ch, output int h, output int l);
      int n;
      n = 0; h = 0; l = 0;
      @(negedge clk_in);
      while (div_clk_out[ch] !== 1'b0 && n < 200) begin @(negedge clk_in); n++; end
      while (div_clk_out[ch] !== 1'b1 && n < 200) begin @(negedge clk_in); n++; end
      while (div_clk_out[ch] === 1'b1 && n < 200) begin @(negedge clk_in); n++; h++; end
      while (div_clk_out[ch] === 1'b0 && n < 200) begin @(negedge clk_in); n++; l++; end
      if (n >= 200) begin fail_count++; results(); end
   endtask
   // Cycles from a sync request to the first rise of channel 0
   task sync_delay(output int t);
      @(posedge clk_in);
      sync_in <= 1;
      repeat (4) @(posedge clk_in);
      t = 4;
      @(negedge clk_in);
      while (div_clk_out[0] !== 1'b1 && t < 200) begin @(negedge clk_in); t++; end
      @(posedge clk_in);
      sync_in <= 0;
      if (t >= 200) begin fail_count++; results(); end
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task sc_reset;
      apb(0, `PCD_IDX_DIV0_COUNTS, 8'h00); check("counts reset", 32'h0, rd);
      apb(0, `PCD_IDX_DIV1_BYPASS, 8'h00); check("bypass reset", 32'h0, rd);
      apb(0, 12'h100, 8'h00); check("unmapped err", 32'h1, {31'h0, err});
      apb(1, `PCD_IDX_STATUS, 8'hff); check("status write err", 32'h1, {31'h0, err});
   endtask
   task sc_ratio;
      apb(1, `PCD_IDX_DIV0_CORR, 8'h01); // Correction off on divider 0
      apb(1, `PCD_IDX_DIV0_COUNTS, 8'h30);
      apb(0, `PCD_IDX_DIV0_COUNTS, 8'h00); check("counts readback", 32'h30, rd);
      measure(0, hi, lo);
      check("div0 high", 32'd1, hi);
      check("div0 low", 32'd4, lo);
      apb(1, `PCD_IDX_DIV1_COUNTS, 8'h22);
      measure(1, hi, lo);
      check("div1 period", 32'd6, hi + lo);
      check("div1 even fix", 32'h0, {31'h0, duty_fix_out[1]});
   endtask
   task sc_correct;
      apb(1, `PCD_IDX_DIV2_COUNTS, 8'h21);
      measure(2, hi, lo);
      check("div2 high", 32'd2, hi);
      check("div2 low", 32'd3, lo);
      check("div2 fix", 32'h1, {31'h0, duty_fix_out[2]});
   endtask
   task sc_bypass;
      apb(1, `PCD_IDX_DIV1_BYPASS, 8'h80);
      repeat (20) @(posedge clk_in);
      check("div1 bypass", 32'h1, {31'h0, bypass_out[1]});
      check("div1 idle", 32'h0, {31'h0, div_clk_out[1]});
      apb(1, `PCD_IDX_DIV1_BYPASS, 8'h00);
      repeat (20) @(posedge clk_in);
      check("div1 unbypass", 32'h0, {31'h0, bypass_out[1]});
      measure(1, hi, lo);
      check("div1 resumes", 32'd6, hi + lo);
   endtask
   task sc_phase;
      sync_delay(t0);
      apb(1, `PCD_IDX_DIV0_BYPASS, 8'h05);
      sync_delay(t1);
      check("phase shift", 32'd5, t1 - t0);
      // Start high, phase 2, M=3: delay 2-0+3+1 from a start-high edge that
      // leads the start-low reference by M+1 cycles, so the rise moves by 2
      apb(1, `PCD_IDX_DIV0_BYPASS, 8'h12);
      sync_delay(t2);
      check("start high shift", 32'd2, t2 - t0);
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      rst_in <= 0;
      sc_reset();
      sc_ratio();
      sc_correct();
      sc_bypass();
      sc_phase();
      results();
   end
endmodule // tb_pcd_channel_dividers
